// *** shared/timer16_pkg.sv ***
// Constants and carrier types for the 16-bit capture/event timer
package timer16_pkg;

  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CNT_W            = 16;
  // Run-mode field of the mode control register
  localparam int unsigned RUN_LO_POS       = 2;
  localparam int unsigned RUN_HI_POS       = 3;
  // Edge-select and count clock source fields of the prescaler mode register
  localparam int unsigned EDGE_A_LO_POS    = 4;
  localparam int unsigned EDGE_A_HI_POS    = 5;
  localparam int unsigned PRESCALE_SEL_LO  = 0;
  localparam int unsigned PRESCALE_SEL_HI  = 1;
  // Output control register fields
  localparam int unsigned OUT_EN_POS       = 0;
  localparam int unsigned TOGGLE_POS       = 1;
  // Capture/compare control: capcmp_a capture bit, never read by the timer; capcmp_a never captures
  localparam int unsigned CCA_CAPTURE_POS  = 0;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam logic [7:0]  PRESCALE_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [15:0] COUNT_MAX        = 16'hffff;
  localparam logic [15:0] COUNT_ZERO       = 16'h0000;
  localparam logic [15:0] COUNT_ONE        = 16'h0001;
  // Run-mode codes
  localparam logic [1:0]  RUN_STOP         = 2'h0;
  localparam logic [1:0]  RUN_CLEAR_MATCH  = 2'h3;
  localparam logic [1:0]  RUN_RESTART      = 2'h2;
  // Edge-select codes
  localparam logic [1:0]  EDGE_FALL        = 2'h0;
  localparam logic [1:0]  EDGE_RISE        = 2'h1;
  localparam logic [1:0]  EDGE_BOTH        = 2'h3;
  // Count clock source codes (prescaler low bits)
  localparam logic [1:0]  CLK_SRC_EDGE     = 2'h3;
  // Prescaler divide exponents for codes 0..2
  localparam int unsigned DIV_EXP0         = 1;
  localparam int unsigned DIV_EXP1         = 2;
  localparam int unsigned DIV_EXP2         = 3;

  typedef struct packed {
    logic [7:0] mode_ctrl_reg;
    logic [7:0] prescale_mode_reg;
    logic [7:0] capcmp_ctrl_reg;
    logic [7:0] out_ctrl_reg;
  } ctrl_t;

  typedef struct packed {
    logic match_a_irq;
    logic match_b_irq;
    logic overflow_flag;
  } event_t;

endpackage : timer16_pkg

// *** src/edge_filter2.sv ***
// Two-sample edge filter with synchroniser
module edge_filter2
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic sample_en,
  input  wire logic run,
  input  wire logic [1:0] edge_sel,
  output logic      edge_hit
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic smp1;
    logic smp2;
    logic level;
    logic edge_hit;
    logic ran;
  } filt_state_t;

  filt_state_t st;
  filt_state_t next_st;

  always_comb
  begin
    next_st          = st;
    next_st.sync1    = pin;
    next_st.sync2    = st.sync1;
    next_st.edge_hit = 1'b0;
    if (run)
      next_st.ran = 1'b1;
    if (!run)
    begin
      // Stopped: no filtering. Once started, level follows the pin so
      // a restart sees no stale edge; before the first start it stays
      // low, so a pin held high reads as a rising edge
      next_st.smp1  = st.sync2;
      next_st.smp2  = st.sync2;
      if (st.ran)
        next_st.level = st.sync2;
    end
    else if (sample_en)
    begin
      next_st.smp1 = st.sync2;
      next_st.smp2 = st.smp1;
      if ((st.smp1 != st.level) && (st.smp2 != st.level))
      begin
        next_st.level = st.smp1;
        case (edge_sel)
          timer16_pkg::EDGE_FALL: next_st.edge_hit = ~st.smp1;
          timer16_pkg::EDGE_RISE: next_st.edge_hit = st.smp1;
          timer16_pkg::EDGE_BOTH: next_st.edge_hit = 1'b1;
          default:                next_st.edge_hit = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st <= '0;   // Level starts low: a high pin after reset is an edge
    else
      st <= next_st;
  end

  assign edge_hit = st.edge_hit;

  property p_filter_two;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(edge_hit) |-> $past(run);
  endproperty
  a_filter_two: assert property (p_filter_two)
    else $error("edge accepted while stopped");

endmodule // edge_filter2

// *** src/timer16_capture_event_unit.sv ***
// 16-bit timer with restart capture, event count and square wave output
// Behaviour
// - Restart mode: valid edge copies counter to capcmp_b, then counter clears.
// - Edge select bits 4,5 pick rising, falling or both edges.
// - Capture trigger accepted after two equal samples at count clock.
// - Both-edge selection blocks capture into capcmp_a.
// - Event mode counts one per filtered valid input edge.
// - Event mode: counter equal capcmp_a clears to zero, raises match A.
// - Edge as count clock is filtered at main clock, two samples.
// - capcmp_b zero: match B after overflow or match with capcmp_a.
// - Event counter mode: shared pin never drives timer output.
// - Output enable plus toggle bit: invert output each capcmp_a interval.
// - First match after start may be one count clock late.
// - Capture during read completes; read data undefined; match B set on the next count clock rise.
// - Capture coinciding with stop is dropped; capcmp_b keeps its value.
// - Clear-on-match with capcmp_a FFFF sets overflow on FFFF to 0000.
// - Overflow flag clear before next count clock is ignored.
// - Counter reads never capture; stopped timer does no filtering.
// - Edge as count clock blocks its capture; compare registers ignore triggers.
// - Capture on count clock fall, interrupt on the next count rise.
// - High pin after reset gives immediate rising edge, not after restart.
// - Valid capture edge loads counter to capcmp_b, sets match B.
// - Clear-and-start: match with capcmp_a restarts from zero, match A.
module timer16_capture_event_unit
#(
  parameter int unsigned CNT_W = timer16_pkg::CNT_W
)
(
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire timer16_pkg::ctrl_t  ctrl,
  input  wire logic [CNT_W-1:0]    capcmp_a_wdata,
  input  wire logic                capcmp_a_we,
  input  wire logic [CNT_W-1:0]    capcmp_b_wdata,
  input  wire logic                capcmp_b_we,
  input  wire logic                overflow_clr,
  input  wire logic                ext_in_a,
  output logic [CNT_W-1:0]         count_reg16,
  output logic [CNT_W-1:0]         capcmp_a,
  output logic [CNT_W-1:0]         capcmp_b,
  output timer16_pkg::event_t      events,
  output logic                     timer_out,
  output logic                     timer_out_oe
);

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_RISE = 4'h2,
    PH_FALL = 4'h4,
    PH_HOLD = 4'h8
  } phase_t;

  typedef struct packed {
    phase_t           phase;
    logic [2:0]       div;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cca;
    logic [CNT_W-1:0] ccb;
    logic             cap_pend;
    logic             irq_a_pend;
    logic             irq_b_pend;
    logic             irq_a;
    logic             irq_b;
    logic             ovf;
    logic             ovf_guard;
    logic             tout;
    logic             tout_oe;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic [1:0] run_mode;
  logic [1:0] edge_sel;
  logic [1:0] clk_src;
  logic       running;
  logic       edge_clock;
  logic       tick_en;
  logic       tick_rise;
  logic       tick_fall;
  logic       edge_hit;
  logic [2:0] div_mask;

  assign run_mode = {ctrl.mode_ctrl_reg[timer16_pkg::RUN_HI_POS],
                     ctrl.mode_ctrl_reg[timer16_pkg::RUN_LO_POS]};
  assign edge_sel = {ctrl.prescale_mode_reg[timer16_pkg::EDGE_A_HI_POS],
                     ctrl.prescale_mode_reg[timer16_pkg::EDGE_A_LO_POS]};
  assign clk_src  = {ctrl.prescale_mode_reg[timer16_pkg::PRESCALE_SEL_HI],
                     ctrl.prescale_mode_reg[timer16_pkg::PRESCALE_SEL_LO]};
  assign running    = (run_mode != timer16_pkg::RUN_STOP);
  assign edge_clock = (clk_src == timer16_pkg::CLK_SRC_EDGE);

  // ----------------------------------------------------------------
  // Count clock: internal divider, rise and fall as phase strobes
  // ----------------------------------------------------------------
  always_comb
  begin
    case (clk_src)
      2'h0:    div_mask = 3'((1 << timer16_pkg::DIV_EXP0) - 1);
      2'h1:    div_mask = 3'((1 << timer16_pkg::DIV_EXP1) - 1);
      2'h2:    div_mask = 3'((1 << timer16_pkg::DIV_EXP2) - 1);
      default: div_mask = 3'h0;
    endcase
  end

  // Edge-driven counting samples at main clock; capture at count clock
  assign tick_rise = running && !edge_clock && ((st.div & div_mask) == 3'h0);
  assign tick_fall = running && !edge_clock
                     && ((st.div & div_mask) == ((div_mask >> 1) + 3'h1));
  assign tick_en   = edge_clock ? running : tick_rise;

  edge_filter2 u_filter_a
  (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin       (ext_in_a),
    .sample_en (tick_en),
    .run       (running),
    .edge_sel  (edge_sel),
    .edge_hit  (edge_hit)
  );

  // ----------------------------------------------------------------
  // Main state update
  // ----------------------------------------------------------------
  logic             count_step;
  logic             cap_ok;
  logic             match_a;
  logic [CNT_W-1:0] count_inc;

  assign count_step = edge_clock ? (running && edge_hit) : tick_rise;
  // Restart capture only when pin edge is a trigger, not a clock
  assign cap_ok  = edge_hit && !edge_clock
                   && (run_mode == timer16_pkg::RUN_RESTART);
  assign match_a = (st.count == st.cca);
  assign count_inc = st.count + timer16_pkg::COUNT_ONE;

  always_comb
  begin
    next_st       = st;
    next_st.irq_a = 1'b0;
    next_st.irq_b = 1'b0;
    next_st.div   = running ? st.div + 3'h1 : 3'h0;
    next_st.phase = running ? st.phase : PH_IDLE;
    // Compare registers written whenever their write strobe is set, running or stopped, except a capcmp_b write that meets a capture
    if (capcmp_a_we)
      next_st.cca = capcmp_a_wdata;
    if (capcmp_b_we)
      next_st.ccb = capcmp_b_wdata;
    if (cap_ok)
      next_st.cap_pend = 1'b1;
    // capcmp_a never captures here; both-edge selects leave it intact
    case (st.phase)
      PH_IDLE:
      begin
        if (running)
          next_st.phase = PH_RISE;
      end
      PH_RISE:
      begin
        if (tick_fall || edge_clock)
          next_st.phase = PH_FALL;
      end
      PH_FALL:
      begin
        if (st.cap_pend && (tick_fall || edge_clock))
        begin
          next_st.ccb        = st.count;
          next_st.count      = timer16_pkg::COUNT_ZERO;
          next_st.cap_pend   = 1'b0;
          next_st.irq_b_pend = 1'b1;
          next_st.phase      = PH_HOLD;
        end
        else if (count_step)
        begin
          if (match_a && run_mode != timer16_pkg::RUN_RESTART)
          begin
            next_st.count      = timer16_pkg::COUNT_ZERO;
            next_st.irq_a      = 1'b1;
            if (st.ccb == timer16_pkg::COUNT_ZERO)
              next_st.irq_b    = 1'b1;
            if (st.tout_oe && ctrl.out_ctrl_reg[timer16_pkg::TOGGLE_POS])
              next_st.tout     = ~st.tout;
            if (st.cca == timer16_pkg::COUNT_MAX)
            begin
              next_st.ovf       = 1'b1;
              next_st.ovf_guard = 1'b1;
            end
          end
          else
          begin
            next_st.count = count_inc;
            if (st.count == timer16_pkg::COUNT_MAX)
            begin
              next_st.ovf       = 1'b1;
              next_st.ovf_guard = 1'b1;
              if (st.ccb == timer16_pkg::COUNT_ZERO)
                next_st.irq_b   = 1'b1;
            end
            else
              next_st.ovf_guard = 1'b0;
          end
        end
      end
      PH_HOLD:
      begin
        if (tick_rise || edge_clock)
        begin
          next_st.irq_b      = st.irq_b_pend;
          next_st.irq_b_pend = 1'b0;
          next_st.phase      = PH_FALL;
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase
    // Overflow clear loses to set, and is void until counter leaves zero
    if (overflow_clr && !st.ovf_guard && !next_st.ovf_guard)
      next_st.ovf = 1'b0;
    if (!running)
    begin
      // a capture racing the stop is simply dropped
      next_st.count     = timer16_pkg::COUNT_ZERO;
      next_st.cap_pend  = 1'b0;
      next_st.ovf_guard = 1'b0;
    end
    // Shared pin is an input while event counting
    next_st.tout_oe = ctrl.out_ctrl_reg[timer16_pkg::OUT_EN_POS]
                      && !edge_clock;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st       <= '0;
      st.phase <= PH_IDLE;
    end
    else
      st <= next_st;
  end

  assign count_reg16  = st.count;  // Reading never captures
  assign capcmp_a     = st.cca;
  assign capcmp_b     = st.ccb;
  assign events       = '{match_a_irq: st.irq_a, match_b_irq: st.irq_b,
                          overflow_flag: st.ovf};
  assign timer_out    = st.tout;
  assign timer_out_oe = st.tout_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_no_out_event;
    @(posedge ref_clk) disable iff (!rst_n)
      edge_clock |=> !timer_out_oe;
  endproperty
  a_no_out_event: assert property (p_no_out_event)
    else $error("timer output driven in event mode");

  logic match_a_irq_cause;
  assign match_a_irq_cause = running && st.phase == PH_FALL && !st.cap_pend
    && count_step && match_a && run_mode != timer16_pkg::RUN_RESTART;
  property p_match_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      match_a_irq_cause |=> (st.count == timer16_pkg::COUNT_ZERO)
                            && events.match_a_irq;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("match did not clear counter");

  property p_event_count;
    @(posedge ref_clk) disable iff (!rst_n)
      (edge_clock && running && edge_hit && st.phase == PH_FALL && !match_a)
        |=> st.count == $past(st.count) + 16'h0001;
  endproperty
  a_event_count: assert property (p_event_count)
    else $error("event edge not counted");

  property p_capture;
    @(posedge ref_clk) disable iff (!rst_n)
      (st.phase == PH_FALL && st.cap_pend && tick_fall && running)
        |=> capcmp_b == $past(st.count) && st.count == 16'h0000;
  endproperty
  a_capture: assert property (p_capture)
    else $error("restart capture wrong");

  property p_ovf_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (st.ovf_guard && events.overflow_flag && running) |=> events.overflow_flag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow cleared too early");

  property p_toggle;
    @(posedge ref_clk) disable iff (!rst_n)
      (match_a_irq_cause && st.tout_oe
       && ctrl.out_ctrl_reg[timer16_pkg::TOGGLE_POS])
        |=> timer_out != $past(timer_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("square wave did not toggle");

  property p_irq_b_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (match_a_irq_cause && capcmp_b == 16'h0000) |=> events.match_b_irq;
  endproperty
  a_irq_b_zero: assert property (p_irq_b_zero)
    else $error("zero capcmp_b gave no match B");

  property p_no_cap_edge_clk;
    @(posedge ref_clk) disable iff (!rst_n)
      edge_clock |-> !cap_ok;
  endproperty
  a_no_cap_edge_clk: assert property (p_no_cap_edge_clk)
    else $error("capture with edge count clock");

endmodule // timer16_capture_event_unit

// *** verification/ext_pulse_src.sv ***
// Model of the external pulse source and timer output load on the pin
module ext_pulse_src
(
  input  wire logic        ref_clk,
  input  wire logic        timer_out,
  input  wire logic        timer_out_oe,
  output logic             ext_in_a,
  output logic [15:0]      toggles
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        src_lvl  = 1'b0;
  logic        prev_lvl = 1'b0;
  logic [15:0] tog_cnt  = 16'h0000;

  // Pin level: the timer output wins only while it drives the pin
  assign ext_in_a = timer_out_oe ? timer_out : src_lvl;
  assign toggles  = tog_cnt;

  // Load side: count level changes while the timer drives the pin
  always @(posedge ref_clk)
  begin
    if (timer_out_oe === 1'b1 && ext_in_a !== prev_lvl)
      tog_cnt <= tog_cnt + 16'h0001;
    prev_lvl <= ext_in_a;
  end

  // Pulses last several cycles so the two-sample filter accepts them
  task automatic emit(input int n, input int half);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1 src_lvl = 1'b1;
      repeat (half) @(posedge ref_clk);
      #1 src_lvl = 1'b0;
      repeat (half - 1) @(posedge ref_clk);
    end
  endtask

  // Steady level, as from a pull-up or a quiet source
  task automatic hold_level(input logic v);
    @(posedge ref_clk);
    #1 src_lvl = v;
  endtask
endmodule // ext_pulse_src

// *** verification/timer16_capture_event_unit_tb_top.sv ***
// Self-checking bench for the 16-bit capture/event timer
module timer16_capture_event_unit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 ref_clk;
  logic                 rst_n;
  timer16_pkg::ctrl_t   ctrl;
  logic [15:0]          a_wdata;
  logic                 a_we;
  logic [15:0]          b_wdata;
  logic                 b_we;
  logic                 overflow_clr;
  logic                 pin;
  logic [15:0]          count_reg16;
  logic [15:0]          capcmp_a;
  logic [15:0]          capcmp_b;
  timer16_pkg::event_t  events;
  logic                 timer_out;
  logic                 timer_out_oe;
  logic [15:0]          toggles;
  int                   error_cnt;
  int                   checks_done;
  int                   na;
  int                   nb;

  `define CHK(nm, exp, got) \
    begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

  timer16_capture_event_unit u_dut
  (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .ctrl           (ctrl),
    .capcmp_a_wdata (a_wdata),
    .capcmp_a_we    (a_we),
    .capcmp_b_wdata (b_wdata),
    .capcmp_b_we    (b_we),
    .overflow_clr   (overflow_clr),
    .ext_in_a       (pin),
    .count_reg16    (count_reg16),
    .capcmp_a       (capcmp_a),
    .capcmp_b       (capcmp_b),
    .events         (events),
    .timer_out      (timer_out),
    .timer_out_oe   (timer_out_oe)
  );

  ext_pulse_src u_src
  (
    .ref_clk      (ref_clk),
    .timer_out    (timer_out),
    .timer_out_oe (timer_out_oe),
    .ext_in_a     (pin),
    .toggles      (toggles)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Interrupt pulses last one cycle, so they are tallied every edge
  always @(posedge ref_clk)
  begin
    if (rst_n !== 1'b1)
    begin
      na <= 0;
      nb <= 0;
    end
    else
    begin
      if (events.match_a_irq === 1'b1)
        na <= na + 1;
      if (events.match_b_irq === 1'b1)
        nb <= nb + 1;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic apply_reset();
    #1 rst_n = 1'b0;
    ctrl = '0;
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
  endtask

  // Compare registers are written only while stopped
  task automatic set_a(input logic [15:0] v);
    @(posedge ref_clk);
    #1 ctrl.mode_ctrl_reg = timer16_pkg::MODE_RESET;
    a_wdata = v;
    a_we = 1'b1;
    @(posedge ref_clk);
    #1 a_we = 1'b0;
  endtask

  task automatic set_b(input logic [15:0] v);
    @(posedge ref_clk);
    #1 ctrl.mode_ctrl_reg = timer16_pkg::MODE_RESET;
    b_wdata = v;
    b_we = 1'b1;
    @(posedge ref_clk);
    #1 b_we = 1'b0;
  endtask

  // Unknowns must fail the range test, so the value is not an int
  task automatic in_range(string nm, logic [31:0] v, int lo, int hi);
    `CHK(nm, 1'b1, (v >= lo && v <= hi))
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset();
    apply_reset();
    repeat (20) @(posedge ref_clk);
    `CHK("count", 16'h0000, count_reg16)
    `CHK("capcmp_b", 16'h0000, capcmp_b)
    `CHK("events", 3'h0, events)
    `CHK("oe", 1'b0, timer_out_oe)
  endtask

  // Five pulses, limit 3: wrap after every fourth edge
  task automatic sc_event();
    logic [1:0] codes [3];
    int edges;
    codes = '{timer16_pkg::EDGE_RISE, timer16_pkg::EDGE_FALL,
              timer16_pkg::EDGE_BOTH};
    foreach (codes[i])
    begin
      apply_reset();
      set_a(16'h0003);
      // Edge select changes only while run bits are clear
      ctrl.prescale_mode_reg = {2'h0, codes[i], 2'h0, 2'h3};
      ctrl.out_ctrl_reg = 8'h03;
      ctrl.mode_ctrl_reg = 8'h0c;
      u_src.emit(5, 8);
      repeat (12) @(posedge ref_clk);
      edges = (codes[i] == timer16_pkg::EDGE_BOTH) ? 10 : 5;
      `CHK("count", 16'(edges % 4), count_reg16)
      `CHK("match_a", edges / 4, na)
      `CHK("match_b", edges / 4, nb)
      `CHK("oe event", 1'b0, timer_out_oe)
      `CHK("toggles", 16'h0000, toggles)
    end
  endtask

  task automatic sc_restart();
    logic [15:0] held;
    int nb0;
    apply_reset();
    ctrl.prescale_mode_reg = 8'h10;
    ctrl.mode_ctrl_reg = 8'h08;
    u_src.emit(3, 40);
    repeat (30) @(posedge ref_clk);
    in_range("capture width", capcmp_b, 38, 42);
    in_range("match_b count", nb, 2, 3);
    in_range("count after", count_reg16, 46, 50);
    `CHK("capcmp_a", 16'h0000, capcmp_a)
    // Both edges: still no capture into capcmp_a
    #1 ctrl.mode_ctrl_reg = 8'h00;
    @(posedge ref_clk);
    #1 ctrl.prescale_mode_reg = 8'h30;
    ctrl.mode_ctrl_reg = 8'h08;
    u_src.emit(2, 40);
    `CHK("capcmp_a both", 16'h0000, capcmp_a)
    // Stopped: pin edges neither capture nor interrupt
    #1 ctrl.mode_ctrl_reg = 8'h00;
    held = capcmp_b;
    nb0 = nb;
    u_src.emit(2, 40);
    `CHK("capcmp_b stop", held, capcmp_b)
    `CHK("match_b stop", nb0, nb)
  endtask

  // Limit 4 at count/2: a toggle every 10 cycles
  task automatic sc_square();
    int t0;
    int a0;
    apply_reset();
    set_a(16'h0004);
    set_b(16'h0002);
    ctrl.prescale_mode_reg = 8'h00;
    ctrl.out_ctrl_reg = 8'h03;
    ctrl.mode_ctrl_reg = 8'h0c;
    repeat (30) @(posedge ref_clk);
    t0 = toggles;
    a0 = na;
    repeat (200) @(posedge ref_clk);
    // One toggle interval of slack on each side
    in_range("toggles", toggles - t0, 19, 21);
    in_range("match_a", na - a0, 19, 21);
    `CHK("oe square", 1'b1, timer_out_oe)
    `CHK("capcmp_b square", 16'h0002, capcmp_b)
    `CHK("match_b nonzero", 0, nb)
  endtask

  // Pin high from reset: first start sees a rise, a restart does not
  task automatic sc_pullup();
    int nb0;
    apply_reset();
    u_src.hold_level(1'b1);
    repeat (4) @(posedge ref_clk);
    #1 ctrl.prescale_mode_reg = 8'h10;
    ctrl.mode_ctrl_reg = 8'h08;
    repeat (20) @(posedge ref_clk);
    `CHK("match_b pullup", 1, nb)
    #1 ctrl.mode_ctrl_reg = 8'h00;
    repeat (4) @(posedge ref_clk);
    #1 ctrl.mode_ctrl_reg = 8'h08;
    nb0 = nb;
    repeat (20) @(posedge ref_clk);
    `CHK("match_b rerun", nb0, nb)
    u_src.hold_level(1'b0);
  endtask

  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    rst_n = 1'b0;
    ctrl = '0;
    a_wdata = 16'h0000;
    a_we = 1'b0;
    b_wdata = 16'h0000;
    b_we = 1'b0;
    overflow_clr = 1'b0;
    @(posedge ref_clk);
    sc_reset();
    sc_event();
    sc_restart();
    sc_square();
    sc_pullup();
    wrap_up();
  end

  // Guard against a hang
  initial
  begin
    #500000;
    error_cnt++;
    wrap_up();
  end
endmodule // timer16_capture_event_unit_tb_top
